// *** verilog/pdc_pkg.sv ***
// Package: constants, register map and carrier types of the power-down controller
package pdc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned RELEASE_MS   = 128;
  localparam int unsigned OSC_START_MS = 150;
  localparam int unsigned LOCK_US      = 1000;
  localparam int unsigned RELEASE_CYC  = RELEASE_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_CYC      = OSC_START_MS * (CLK_HZ / 1000);
  localparam int unsigned LOCK_CYC     = LOCK_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W        = 25;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PWR_CTL_OFS  = 12'h000;
  localparam logic [11:0] LOOP_CTL_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS   = 12'h008;

  // Power control fields
  localparam int PWR_DOWN_BIT    = 1;
  localparam int SERIAL_WAKE_BIT = 4;
  localparam int INT0_WAKE_BIT   = 5;
  localparam logic [7:0] PWR_CTL_RST = 8'h00;

  // Loop control fields
  localparam int CORE_DIV_LSB  = 0;
  localparam int CORE_DIV_W    = 3;
  localparam int OSC_SLEEP_BIT = 5;
  localparam int LOCK_BIT      = 6;
  localparam logic [7:0] LOOP_CTL_RST = 8'h03;

  // Status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LOCK_BIT  = 4;
  localparam int STAT_OSCW_BIT  = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PM_RUN  = 4'b0001,
    PM_DOWN = 4'b0010,
    PM_OSC  = 4'b0100,
    PM_LOCK = 4'b1000
  } pdc_pm_state_t;

  typedef enum logic [3:0] {
    POR_HOLD = 4'b0001,
    POR_TIME = 4'b0010,
    POR_RUN  = 4'b0100,
    POR_FALL = 4'b1000
  } pdc_por_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pdc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pdc_apb_rsp_t;

  typedef struct packed {
    logic ticIrq;
    logic ticEn;
    logic spiIrq;
    logic spiEn;
    logic int0Irq;
    logic int0En;
  } pdc_wake_req_t;

  typedef struct packed {
    logic pllEnable;
    logic oscEnable;
    logic coreClkEn;
    logic coreClkAccurate;
    logic ticEnable;
    logic periphEnable;
    logic portHold;
    logic dacOutEn;
    logic aleOut;
    logic progStrobeOut;
  } pdc_pad_ctl_t;

endpackage

// *** verilog/pdc_por_timer.sv ***
// Power-on reset: supply threshold tracking and release timer
`timescale 1ns/100ps
module pdc_por_timer #(
  parameter bit          FIVE_VOLT   = 1'b0,
  parameter int unsigned RELEASE_CNT = pdc_pkg::RELEASE_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Supply comparators
  input  wire logic aboveLowThr,
  input  wire logic aboveHighThr,
  input  wire logic aboveFloor,
  // Result
  output logic      porHeld
);
  import pdc_pkg::*;

  generate
    if (RELEASE_CNT < 1 || RELEASE_CNT >= (1 << CNT_W)) begin : g_chk
      $error("RELEASE_CNT out of range");
    end
  endgenerate

  typedef struct packed {
    pdc_por_state_t      st;
    logic [CNT_W-1:0]    cnt;
    logic                held;
  } pdc_por_reg_t;

  pdc_por_reg_t cur_ff;
  pdc_por_reg_t nxt_ff;
  logic         aboveRelease;

  // Variant selects which threshold releases the chip
  assign aboveRelease = FIVE_VOLT ? aboveHighThr : aboveLowThr;

  always_comb begin
    nxt_ff = cur_ff;
    case (cur_ff.st)
      POR_HOLD: begin
        nxt_ff.cnt = '0;
        if (aboveRelease) begin
          nxt_ff.st = POR_TIME;
        end
      end
      POR_TIME: begin
        if (!aboveRelease) begin
          nxt_ff.st  = POR_HOLD;
          nxt_ff.cnt = '0;
        end else if (cur_ff.cnt == CNT_W'(RELEASE_CNT - 1)) begin
          nxt_ff.st = POR_RUN;
        end else begin
          nxt_ff.cnt = cur_ff.cnt + CNT_W'(1);
        end
      end
      POR_RUN: begin
        if (!aboveRelease) begin
          nxt_ff.st = POR_FALL;
        end
      end
      POR_FALL: begin
        // Held until the supply is gone; a recovery restarts the full delay
        if (!aboveFloor) begin
          nxt_ff.st = POR_HOLD;
        end else if (aboveRelease) begin
          nxt_ff.st  = POR_TIME;
          nxt_ff.cnt = '0;
        end
      end
      default: nxt_ff.st = POR_HOLD;
    endcase
    nxt_ff.held = (nxt_ff.st != POR_RUN);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '{st: POR_HOLD, cnt: '0, held: 1'b1};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign porHeld = cur_ff.held;

endmodule

// *** verilog/pdc_power_ctrl.sv ***
// Power-down sequencer with reset control and APB register slave
`timescale 1ns/100ps
module pdc_power_ctrl #(
  parameter bit          FIVE_VOLT   = 1'b0,
  parameter int unsigned RELEASE_CNT = pdc_pkg::RELEASE_CYC,
  parameter int unsigned OSC_CNT     = pdc_pkg::OSC_CYC,
  parameter int unsigned LOCK_CNT    = pdc_pkg::LOCK_CYC
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Register bus
  input  wire pdc_pkg::pdc_apb_req_t apbReq,
  output pdc_pkg::pdc_apb_rsp_t      apbRsp,
  // Supply comparators and reset pin
  input  wire logic                  aboveLowThr,
  input  wire logic                  aboveHighThr,
  input  wire logic                  aboveFloor,
  input  wire logic                  extReset_n,
  // Wake sources from the core
  input  wire pdc_pkg::pdc_wake_req_t wakeReq,
  // Strobes from the core
  input  wire logic                  aleIn,
  input  wire logic                  progStrobeIn,
  // Clock, pad and peripheral control
  output pdc_pkg::pdc_pad_ctl_t      padCtl,
  // Core sequencing
  output logic                       coreReset,
  output logic                       vectorStart,
  output logic [2:0]                 wakeIrq
);
  import pdc_pkg::*;

  generate
    if (OSC_CNT < 1 || OSC_CNT >= (1 << CNT_W)) begin : g_chk_osc
      $error("OSC_CNT out of range");
    end
    if (LOCK_CNT < 1 || LOCK_CNT >= (1 << CNT_W)) begin : g_chk_lock
      $error("LOCK_CNT out of range");
    end
    // The divider counter must cover the slowest core divide ratio
    if ((1 << CORE_DIV_W) - 1 > 7) begin : g_chk_div
      $error("divider counter too narrow");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pdc_pm_state_t    st;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       pwrCtl;
    logic [7:0]       loopCtl;
    logic             oscStopped;
    logic             locked;
    logic             coreRst;
    logic             vecStart;
    logic [2:0]       wakeIrq;
    logic [6:0]       divCnt;
    pdc_pad_ctl_t     pad;
    logic [31:0]      prdata;
  } pdc_ctl_reg_t;

  pdc_ctl_reg_t cur_ff;
  pdc_ctl_reg_t nxt_ff;
  logic         porHeld;
  logic         chipReset;
  logic         wrEn;
  logic         mapped;
  logic         oscSleep;
  logic         wakeTic;
  logic         wakeSpi;
  logic         wakeInt0;
  logic         down;

  // Power-up image: core held in reset, loop unlocked, pads awake except core clock, tic and strobe outputs
  // The sequencer starts in the lock wait so the loop settles after power-up
  localparam pdc_ctl_reg_t CTL_RST = '{
    st:         PM_LOCK,
    cnt:        '0,
    pwrCtl:     PWR_CTL_RST,
    loopCtl:    LOOP_CTL_RST,
    oscStopped: 1'b0,
    locked:     1'b0,
    coreRst:    1'b1,
    vecStart:   1'b0,
    wakeIrq:    3'h0,
    divCnt:     7'h00,
    pad:        '{
      pllEnable:       1'b1,
      oscEnable:       1'b1,
      coreClkEn:       1'b0,
      coreClkAccurate: 1'b0,
      ticEnable:       1'b0,
      periphEnable:    1'b1,
      portHold:        1'b0,
      dacOutEn:        1'b1,
      aleOut:          1'b0,
      progStrobeOut:   1'b0
    },
    prdata:     32'h0000_0000
  };

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == PWR_CTL_OFS) || (a == LOOP_CTL_OFS) || (a == STATUS_OFS);
  endfunction

  // Low cd bits of a free-running counter keep every ratio an exact power of two
  function automatic logic [6:0] divMask(input logic [CORE_DIV_W-1:0] cd);
    divMask = 7'((8'h01 << cd) - 8'h01);
  endfunction

  function automatic logic [31:0] regRead(input logic [11:0] a, input pdc_ctl_reg_t r);
    logic [31:0] d;
    d = '0;
    if (a == PWR_CTL_OFS) begin
      d[7:0] = r.pwrCtl;
    end else if (a == LOOP_CTL_OFS) begin
      d[7:0]        = r.loopCtl;
      d[LOCK_BIT]   = r.locked;
    end else if (a == STATUS_OFS) begin
      d[STAT_STATE_LSB +: 4] = r.st;
      d[STAT_LOCK_BIT]       = r.locked;
      d[STAT_OSCW_BIT]       = r.oscStopped;
    end
    regRead = d;
  endfunction

  // ----------------------------------------------------------------
  // Power-on reset
  // ----------------------------------------------------------------
  pdc_por_timer #(
    .FIVE_VOLT   (FIVE_VOLT),
    .RELEASE_CNT (RELEASE_CNT)
  ) u_por (
    .clock        (clock),
    .arst_n       (arst_n),
    .aboveLowThr  (aboveLowThr),
    .aboveHighThr (aboveHighThr),
    .aboveFloor   (aboveFloor),
    .porHeld      (porHeld)
  );

  // Either reset source puts the sequencer state and both control registers back to their defaults
  assign chipReset = porHeld || !extReset_n;

  // ----------------------------------------------------------------
  // Bus decode and wake qualification
  // ----------------------------------------------------------------
  // Writes are dropped while any reset source holds; reads still answer
  assign mapped   = isMapped(apbReq.paddr);
  assign wrEn     = apbReq.psel && apbReq.penable && apbReq.pwrite && !chipReset;
  assign oscSleep = cur_ff.loopCtl[OSC_SLEEP_BIT];
  // Each source wakes only with its enable; spi and int0 also need their wake bit, tic needs the oscillator-sleep bit clear
  assign wakeTic  = wakeReq.ticIrq && wakeReq.ticEn && !oscSleep;
  assign wakeSpi  = wakeReq.spiIrq && wakeReq.spiEn &&
                    cur_ff.pwrCtl[SERIAL_WAKE_BIT];
  assign wakeInt0 = wakeReq.int0Irq && wakeReq.int0En &&
                    cur_ff.pwrCtl[INT0_WAKE_BIT];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ff          = cur_ff;
    nxt_ff.wakeIrq  = 3'h0;
    nxt_ff.vecStart = 1'b0;
    nxt_ff.divCnt   = cur_ff.divCnt + 7'h01;
    nxt_ff.prdata   = regRead(apbReq.paddr, cur_ff);

    if (wrEn && apbReq.paddr == PWR_CTL_OFS) begin
      nxt_ff.pwrCtl = apbReq.pwdata[7:0];
    end
    if (wrEn && apbReq.paddr == LOOP_CTL_OFS) begin
      nxt_ff.loopCtl           = apbReq.pwdata[7:0];
      nxt_ff.loopCtl[LOCK_BIT] = 1'b0;
    end

    case (cur_ff.st)
      PM_RUN, PM_LOCK: begin
        if (cur_ff.st == PM_LOCK) begin
          // Core keeps running, clock marked inaccurate until lock
          if (cur_ff.cnt == CNT_W'(LOCK_CNT - 1)) begin
            nxt_ff.st     = PM_RUN;
            nxt_ff.locked = 1'b1;
          end else begin
            nxt_ff.cnt = cur_ff.cnt + CNT_W'(1);
          end
        end
        // Entry latches whether the oscillator sleeps, which picks the wake path
        if (nxt_ff.pwrCtl[PWR_DOWN_BIT]) begin
          nxt_ff.st         = PM_DOWN;
          nxt_ff.oscStopped = nxt_ff.loopCtl[OSC_SLEEP_BIT];
          nxt_ff.locked     = 1'b0;
          nxt_ff.cnt        = '0;
        end
      end
      PM_DOWN: begin
        if (wakeTic || wakeSpi || wakeInt0) begin
          // Interrupt entry, not reset: core returns past the power-down write
          nxt_ff.wakeIrq                = {wakeInt0, wakeSpi, wakeTic};
          nxt_ff.pwrCtl[PWR_DOWN_BIT]   = 1'b0;
          nxt_ff.cnt                    = '0;
          nxt_ff.st = cur_ff.oscStopped ? PM_OSC : PM_LOCK;
        end
      end
      PM_OSC: begin
        // Crystal start-up: the loop stays off until the oscillator settles
        if (cur_ff.cnt == CNT_W'(OSC_CNT - 1)) begin
          nxt_ff.st  = PM_LOCK;
          nxt_ff.cnt = '0;
        end else begin
          nxt_ff.cnt = cur_ff.cnt + CNT_W'(1);
        end
      end
      default: begin
        nxt_ff.st  = PM_LOCK;
        nxt_ff.cnt = '0;
      end
    endcase

    // Any reset source wins over everything, including a pending wake
    nxt_ff.coreRst = chipReset;
    if (chipReset) begin
      nxt_ff.st         = PM_LOCK;
      nxt_ff.cnt        = '0;
      nxt_ff.pwrCtl     = PWR_CTL_RST;
      nxt_ff.loopCtl    = LOOP_CTL_RST;
      nxt_ff.oscStopped = 1'b0;
      nxt_ff.locked     = 1'b0;
      nxt_ff.wakeIrq    = 3'h0;
    end
    if (cur_ff.coreRst && !chipReset) begin
      nxt_ff.vecStart = 1'b1;
    end

    // Pad and clock controls follow the next state so they switch together
    down = (nxt_ff.st == PM_DOWN);
    nxt_ff.pad.pllEnable       = !(down || nxt_ff.st == PM_OSC);
    nxt_ff.pad.oscEnable       = !(down && nxt_ff.loopCtl[OSC_SLEEP_BIT]);
    nxt_ff.pad.coreClkEn       = !down && !chipReset &&
      ((cur_ff.divCnt & divMask(nxt_ff.loopCtl[CORE_DIV_LSB +: CORE_DIV_W])) == 7'h00);
    nxt_ff.pad.coreClkAccurate = nxt_ff.locked;
    nxt_ff.pad.ticEnable       = wakeReq.ticEn && nxt_ff.pad.oscEnable;
    nxt_ff.pad.periphEnable    = !down;
    nxt_ff.pad.portHold        = down;
    nxt_ff.pad.dacOutEn        = !down;
    nxt_ff.pad.aleOut          = !down && aleIn;
    nxt_ff.pad.progStrobeOut   = !down && progStrobeIn;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= CTL_RST;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states; read data is captured during the setup cycle
  assign apbRsp.pready  = 1'b1;
  // Unmapped addresses answer with an error and change nothing
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;
  assign apbRsp.prdata  = cur_ff.prdata;
  assign padCtl         = cur_ff.pad;
  assign coreReset      = cur_ff.coreRst;
  assign vectorStart    = cur_ff.vecStart;
  assign wakeIrq        = cur_ff.wakeIrq;

endmodule

// *** tb/pdc_power_ctrl_asserts.sv ***
// Concurrent checks on the power-down controller ports
`timescale 1ns/100ps
module pdc_power_ctrl_asserts #(
  parameter int unsigned RELEASE_CNT = pdc_pkg::RELEASE_CYC,
  parameter int unsigned OSC_CNT     = pdc_pkg::OSC_CYC,
  parameter int unsigned LOCK_CNT    = pdc_pkg::LOCK_CYC
) (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   arst_n,
  // Watched ports
  input wire pdc_pkg::pdc_apb_req_t  apbReq,
  input wire logic                   aboveLowThr,
  input wire logic                   extReset_n,
  input wire pdc_pkg::pdc_wake_req_t wakeReq,
  input wire pdc_pkg::pdc_pad_ctl_t  padCtl,
  input wire logic                   coreReset,
  input wire logic                   vectorStart,
  input wire logic [2:0]             wakeIrq
);
  import pdc_pkg::*;
  localparam int LK_LO = LOCK_CNT - 1;
  localparam int OS_LO = OSC_CNT - 1;
  // Cycles the comparator has stayed high, saturating
  logic [31:0] upCnt_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upCnt_ff <= 32'h0;
    end else if (!aboveLowThr) begin
      upCnt_ff <= 32'h0;
    end else if (upCnt_ff != 32'hFFFFFFFF) begin
      upCnt_ff <= upCnt_ff + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_held;
    !aboveLowThr |-> ##[1:2] coreReset;
  endproperty
  a_held: assert property (p_held) else $error("reset not held");
  property p_delay;
    $fell(coreReset) |-> upCnt_ff >= RELEASE_CNT;
  endproperty
  a_delay: assert property (p_delay) else $error("early release");
  property p_vector;
    $fell(coreReset) |-> ##[0:1] vectorStart;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector pulse");
  property p_ext;
    !extReset_n |-> ##[1:2] (coreReset && !padCtl.portHold);
  endproperty
  a_ext: assert property (p_ext) else $error("pin reset ignored");
  property p_entry;
    apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.paddr == PWR_CTL_OFS
      && apbReq.pwdata[PWR_DOWN_BIT] && !coreReset && extReset_n && aboveLowThr
      && padCtl.pllEnable && !padCtl.portHold |-> ##[1:2] padCtl.portHold;
  endproperty
  a_entry: assert property (p_entry) else $error("no power-down");
  property p_pads;
    padCtl.portHold |-> !(padCtl.pllEnable || padCtl.coreClkEn || padCtl.periphEnable
      || padCtl.dacOutEn || padCtl.aleOut || padCtl.progStrobeOut);
  endproperty
  a_pads: assert property (p_pads) else $error("pads awake");
  property p_tic;
    padCtl.portHold |-> padCtl.ticEnable == (wakeReq.ticEn && padCtl.oscEnable);
  endproperty
  a_tic: assert property (p_tic) else $error("counter gating");
  property p_wake;
    |wakeIrq |-> $past(padCtl.portHold)
      && (!wakeIrq[0] || $past(wakeReq.ticIrq && wakeReq.ticEn))
      && (!wakeIrq[1] || $past(wakeReq.spiIrq && wakeReq.spiEn))
      && (!wakeIrq[2] || $past(wakeReq.int0Irq && wakeReq.int0En));
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_lock;
    |wakeIrq && padCtl.pllEnable |-> (!padCtl.coreClkAccurate throughout
      (1'b1 ##LK_LO 1'b1)) ##[1:4] padCtl.coreClkAccurate;
  endproperty
  a_lock: assert property (p_lock) else $error("lock timing");
  property p_osc;
    |wakeIrq && !padCtl.pllEnable |-> (!padCtl.pllEnable throughout
      (1'b1 ##OS_LO 1'b1)) ##[1:6] padCtl.pllEnable;
  endproperty
  a_osc: assert property (p_osc) else $error("osc start timing");
endmodule

bind pdc_power_ctrl pdc_power_ctrl_asserts #(
  .RELEASE_CNT(RELEASE_CNT),
  .OSC_CNT(OSC_CNT),
  .LOCK_CNT(LOCK_CNT)
) pdc_power_ctrl_asserts_inst (
  .clock(clock), .arst_n(arst_n), .apbReq(apbReq), .aboveLowThr(aboveLowThr),
  .extReset_n(extReset_n), .wakeReq(wakeReq), .padCtl(padCtl), .coreReset(coreReset),
  .vectorStart(vectorStart), .wakeIrq(wakeIrq)
);

// *** tb/pdc_supply_model.sv ***
// Supply rail model driving the three supply comparators
`timescale 1ns/100ps
module pdc_supply_model (
  // Supply level in millivolts
  input  wire logic [12:0] supplyMv,
  // Comparators
  output logic             aboveLowThr,
  output logic             aboveHighThr,
  output logic             aboveFloor
);
  assign aboveLowThr  = supplyMv > 13'hA46;
  assign aboveHighThr = supplyMv > 13'h1194;
  assign aboveFloor   = supplyMv > 13'h3E8;
endmodule

// *** tb/pdc_power_ctrl_test.sv ***
// Self-checking bench for the power-down controller
`timescale 1ns/100ps
module pdc_power_ctrl_test;
  import pdc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int unsigned REL = 20;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic        e;
  } pdc_row_t;
  pdc_row_t       rows [4] = '{'{12'h004, 32'hFFFFFF02, 32'h42, 1'b0},
                               '{12'h008, 32'hFF, 32'h11, 1'b0},
                               '{12'h00C, 32'h02, 32'h0, 1'b1},
                               '{12'h000, 32'h30, 32'h30, 1'b0}};
  logic           clock;
  logic           arst_n;
  pdc_apb_req_t   apbReq;
  pdc_apb_rsp_t   apbRsp;
  logic [12:0]    supplyMv;
  logic           aboveLowThr;
  logic           aboveHighThr;
  logic           aboveFloor;
  logic           extReset_n;
  pdc_wake_req_t  wakeReq;
  logic           aleIn;
  logic           progStrobeIn;
  pdc_pad_ctl_t   padCtl;
  logic           coreReset;
  logic           vectorStart;
  logic [2:0]     wakeIrq;
  logic           coreReset5;
  logic [31:0]    rd;
  logic [31:0]    pulses;
  logic           err;
  int             n;
  int             fail_count;
  int             num_checks;
  pdc_supply_model pdc_supply_model_inst (.supplyMv, .aboveLowThr, .aboveHighThr, .aboveFloor);
  pdc_power_ctrl #(.FIVE_VOLT(1'b0), .RELEASE_CNT(REL), .OSC_CNT(10), .LOCK_CNT(5))
    pdc_power_ctrl_inst (.clock, .arst_n, .apbReq, .apbRsp, .aboveLowThr, .aboveHighThr,
    .aboveFloor, .extReset_n, .wakeReq, .aleIn, .progStrobeIn, .padCtl, .coreReset,
    .vectorStart, .wakeIrq);
  // Second variant on the same rail: only its reset release is watched
  pdc_power_ctrl #(.FIVE_VOLT(1'b1), .RELEASE_CNT(REL), .OSC_CNT(10), .LOCK_CNT(5))
    pdc_power_ctrl_5v_inst (.clock, .arst_n, .apbReq, .apbRsp(), .aboveLowThr,
    .aboveHighThr, .aboveFloor, .extReset_n, .wakeReq, .aleIn, .progStrobeIn, .padCtl(),
    .coreReset(coreReset5), .vectorStart(), .wakeIrq());
  initial clock = 1'b0;
  always #4 clock = ~clock;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    int k;
    @(posedge clock);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: w};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (apbRsp.pready !== 1'b1 && k < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Bounded waits: release from reset, wake pulse, lock flag
  task automatic waitRun();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (coreReset !== 1'b0 && n < 200);
    check("runWait", coreReset, 1'b0);
  endtask
  task automatic waitWake();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wakeIrq === 3'h0 && n < 60);
  endtask
  task automatic pollLock();
    n = 0;
    do begin
      apb(1'b0, LOOP_CTL_OFS, 32'h0);
      n++;
    end while (rd[LOCK_BIT] !== 1'b1 && n < 40);
    check("lockWait", rd[LOCK_BIT], 1'b1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #(8 * 40000);
    fail_count++;
    results();
  end
  initial begin
    fail_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    apbReq = '0;
    supplyMv = 13'h0;
    extReset_n = 1'b1;
    wakeReq = 6'h15;
    aleIn = 1'b1;
    progStrobeIn = 1'b1;
    cyc(16);
    check("rstPads", {coreReset, padCtl}, 11'h714);
    arst_n <= 1'b1;
    supplyMv <= 13'hCE4;
    cyc(REL / 2);
    supplyMv <= 13'h7D0;
    cyc(2);
    supplyMv <= 13'hCE4;
    cyc(REL / 2 + 4);
    check("dipHeld", coreReset, 1'b1);
    waitRun();
    pollLock();
    check("loopRst", rd, 32'h43);
    check("runPads", padCtl & 10'h37F, 10'h377);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      check("wrErr", err, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      check(rows[i].a == 12'h0 ? "pwrCtl" : "regRd", rd, rows[i].r);
    end
    for (int cd = 0; cd < 4; cd++) begin
      apb(1'b1, LOOP_CTL_OFS, 32'(cd));
      cyc(8);
      pulses = 32'h0;
      repeat (64) begin
        @(posedge clock);
        pulses += {31'h0, padCtl.coreClkEn};
      end
      check("clkPulses", pulses, 32'h40 >> cd);
    end
    // Wake by each source; spi first refused without its wake bit
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, PWR_CTL_OFS, s == 0 ? 32'h02 : 32'h32);
      cyc(3);
      check("downPads", padCtl & 10'h3BF, 10'h128);
      if (s == 0) begin
        wakeReq <= 6'h1D;
        cyc(6);
        check("spiRefused", padCtl.portHold, 1'b1);
      end
      wakeReq <= 6'h15 | (6'h20 >> (2 * s));
      waitWake();
      check("wakeSrc", wakeIrq, 3'h1 << s);
      wakeReq <= 6'h15;
      apb(1'b0, PWR_CTL_OFS, 32'h0);
      check("pdCleared", rd, s == 0 ? 32'h0 : 32'h30);
      pollLock();
      check("accurate", padCtl.coreClkAccurate, 1'b1);
    end
    apb(1'b1, LOOP_CTL_OFS, 32'h20);
    apb(1'b1, PWR_CTL_OFS, 32'h22);
    cyc(3);
    check("sleepPads", padCtl & 10'h3BF, 10'h008);
    wakeReq <= 6'h35;
    cyc(6);
    check("ticRefused", padCtl.portHold, 1'b1);
    wakeReq <= 6'h17;
    waitWake();
    @(posedge clock);
    check("oscStart", padCtl.pllEnable, 1'b0);
    wakeReq <= 6'h15;
    pollLock();
    apb(1'b1, PWR_CTL_OFS, 32'h02);
    cyc(3);
    extReset_n <= 1'b0;
    cyc(4);
    check("extRst", {coreReset, padCtl.portHold}, 2'h2);
    extReset_n <= 1'b1;
    waitRun();
    apb(1'b0, LOOP_CTL_OFS, 32'h0);
    check("loopDflt", rd & 32'hBF, 32'h03);
    apb(1'b1, PWR_CTL_OFS, 32'h02);
    cyc(3);
    supplyMv <= 13'h1F4;
    cyc(4);
    check("pwrOff", coreReset, 1'b1);
    supplyMv <= 13'hCE4;
    cyc(2);
    waitRun();
    check("relDelay", n >= REL && n <= REL + 4, 1'b1);
    check("vector", vectorStart, 1'b1);
    apb(1'b0, PWR_CTL_OFS, 32'h0);
    check("pwrDflt", rd, 32'h0);
    check("hold5V", coreReset5, 1'b1);
    supplyMv <= 13'h12C0;
    cyc(REL);
    check("timing5V", coreReset5, 1'b1);
    cyc(4);
    check("release5V", coreReset5, 1'b0);
    results();
  end
endmodule
